// File: core/cpu_operand_address_generator.sv
// operand byte counting and effective address forming for the 8-bit core
`timescale 1ns/100ps
// Contract
// - inherent mode fetches no byte beyond the opcode
// - immediate mode takes one following byte as the operand value
// - short direct uses one fetched byte as a zero-page address
// - long direct uses a fetched two-byte word as the address
// - indexed address is the unsigned sum of index and offset
// - no-offset indexed fetches nothing; index alone addresses 00 to FF
// - no-offset indexed with second index is one byte longer
// - short indexed adds one fetched byte to index, up to 1FE
// - long indexed adds a fetched two-byte word to index
// - indirect modes read the operand address from a pointer location
// - short indirect reads a byte pointer, address within 00 to FF
// - long indirect reads a word pointer with one byte after opcode
// - relative target is pcNext, the address of the first byte after the opcode, plus signed offset
// - read-modify-write instructions fold long direct and long indexed onto their short forms
// - short indirect indexed adds byte pointer to index, up to 1FE
// - relative indirect reads the offset from a pointed location
// - prebyte 90 swaps the first index register for the second
module cpu_operand_address_generator
    import opaddr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic              start,
    input  wire logic [4:0]        modeIn,
    input  wire logic [DATA_W-1:0] prebyte,
    input  wire logic [DATA_W-1:0] opcode,
    input  wire logic              rmwOp,
    input  wire logic [DATA_W-1:0] indexX,
    input  wire logic [DATA_W-1:0] indexY,
    input  wire logic [ADDR_W-1:0] pcNext,
    output logic                   memReq,
    output logic      [ADDR_W-1:0] memAddr,
    input  wire logic              memValid,
    input  wire logic [DATA_W-1:0] memData,
    output logic                   busy,
    output logic                   done,
    output logic      [ADDR_W-1:0] effAddr,
    output logic      [DATA_W-1:0] immValue,
    output logic      [ADDR_W-1:0] branchTarget,
    output logic      [2:0]        bitNum,
    output logic      [1:0]        operandLen,
    output logic                   useSecondIndex
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    gen_state_e        state_r,  state_nxt;
    addr_mode_e        mode_r,   mode_nxt;
    logic [ADDR_W-1:0] fetch_r,  fetch_nxt;
    logic [ADDR_W-1:0] ea_r,     ea_nxt;
    logic [ADDR_W-1:0] tgt_r,    tgt_nxt;
    logic [DATA_W-1:0] imm_r,    imm_nxt;
    logic [DATA_W-1:0] idx_r,    idx_nxt;
    logic [1:0]        len_r,    len_nxt;
    logic [1:0]        cnt_r,    cnt_nxt;
    logic [2:0]        bit_r,    bit_nxt;
    logic              useY_r,   useY_nxt;
    logic              done_r,   done_nxt;
    logic              ptrLong_r, ptrLong_nxt;
    logic              ptrSecond_r, ptrSecond_nxt;
    logic              asmClear, asmHigh, asmLow;
    logic [ADDR_W-1:0] asmWord;
    logic [ADDR_W-1:0] memAddrC;
    addr_mode_e        modeSel;

    // words from two bytes go through one assembler, high byte first
    byte_word_asm u_asm (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clkEn    (clkEn),
        .clear    (asmClear),
        .loadHigh (asmHigh),
        .loadLow  (asmLow),
        .dataIn   (memData),
        .word     (asmWord)
    );

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic [1:0] bytes_after(input addr_mode_e m, input logic y);
        unique case (m)
            MODE_INHERENT:     bytes_after = 2'd0;
            MODE_IMMEDIATE:    bytes_after = 2'd1;
            MODE_DIR_SHORT:    bytes_after = 2'd1;
            MODE_DIR_LONG:     bytes_after = 2'd2;
            MODE_IDX_NONE:     bytes_after = y ? 2'd1 : 2'd0;
            MODE_IDX_SHORT:    bytes_after = 2'd1;
            MODE_IDX_LONG:     bytes_after = 2'd2;
            MODE_BIT_DIRECT:   bytes_after = 2'd1;
            MODE_BIT_DIR_REL:  bytes_after = 2'd2;
            MODE_BIT_IND_REL:  bytes_after = 2'd2;                 // pointer byte then offset
            MODE_REL_DIRECT:   bytes_after = 2'd1;
            default:           bytes_after = 2'd1;                 // pointer byte only
        endcase
    endfunction : bytes_after

    // prebyte length counted by the opcode fetcher; only the y extra is reported here
    always_comb begin
        modeSel = addr_mode_e'(modeIn);
        // rmw ops cannot use long forms, fold them onto short ones
        if (rmwOp) begin
            if (modeSel == MODE_DIR_LONG) modeSel = MODE_DIR_SHORT;
            if (modeSel == MODE_IDX_LONG) modeSel = MODE_IDX_SHORT;
        end
    end

    // -------------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r; mode_nxt = mode_r; fetch_nxt = fetch_r;
        ea_nxt = ea_r; tgt_nxt = tgt_r; imm_nxt = imm_r; idx_nxt = idx_r;
        len_nxt = len_r; cnt_nxt = cnt_r; bit_nxt = bit_r; useY_nxt = useY_r;
        ptrLong_nxt = ptrLong_r; ptrSecond_nxt = ptrSecond_r;
        done_nxt = 1'b0;
        asmClear = 1'b0; asmHigh = 1'b0; asmLow = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (start) begin
                    useY_nxt  = (prebyte == PREBYTE_Y);
                    idx_nxt   = (prebyte == PREBYTE_Y) ? indexY : indexX;
                    mode_nxt  = modeSel;
                    len_nxt   = bytes_after(modeSel, prebyte == PREBYTE_Y);
                    bit_nxt   = opcode[3:1];
                    fetch_nxt = pcNext;
                    cnt_nxt   = 2'd0;
                    asmClear  = 1'b1;
                    if (modeSel == MODE_INHERENT) begin
                        ea_nxt = ZERO_ADDR; done_nxt = 1'b1;
                    end else if (modeSel == MODE_IDX_NONE) begin
                        ea_nxt = {ZERO_BYTE, (prebyte == PREBYTE_Y) ? indexY : indexX};
                        done_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_OPERAND;
                    end
                end
            end
            ST_OPERAND: begin
                if (memValid) begin
                    fetch_nxt = fetch_r + ONE_ADDR;
                    cnt_nxt   = cnt_r + 2'd1;
                    if (cnt_r == 2'd0) asmHigh = 1'b1;
                    else asmLow = 1'b1;
                    unique case (mode_r)
                        MODE_IMMEDIATE: begin
                            imm_nxt = memData; state_nxt = ST_DONE;
                        end
                        MODE_DIR_SHORT, MODE_BIT_DIRECT: begin
                            ea_nxt = {ZERO_BYTE, memData}; state_nxt = ST_DONE;
                        end
                        MODE_IDX_SHORT: begin
                            ea_nxt = {ZERO_BYTE, memData} + {ZERO_BYTE, idx_r};
                            state_nxt = ST_DONE;
                        end
                        MODE_DIR_LONG, MODE_IDX_LONG: begin
                            if (cnt_r == 2'd1) begin
                                ea_nxt = {asmWord[15:8], memData}
                                    + ((mode_r == MODE_IDX_LONG) ? {ZERO_BYTE, idx_r} : ZERO_ADDR);
                                state_nxt = ST_DONE;
                            end
                        end
                        MODE_IDX_NONE: begin                          // never reached; no-offset indexed completes in ST_IDLE
                            ea_nxt = {ZERO_BYTE, idx_r}; state_nxt = ST_DONE;
                        end
                        MODE_REL_DIRECT: begin
                            tgt_nxt = pcNext + {{8{memData[7]}}, memData};
                            state_nxt = ST_DONE;
                        end
                        MODE_BIT_DIR_REL: begin
                            if (cnt_r == 2'd0) ea_nxt = {ZERO_BYTE, memData};
                            else begin
                                tgt_nxt = pcNext + {{8{memData[7]}}, memData};
                                state_nxt = ST_DONE;
                            end
                        end
                        default: begin                                // pointer location
                            ea_nxt = {ZERO_BYTE, memData};
                            ptrLong_nxt = (mode_r == MODE_IND_LONG) || (mode_r == MODE_INDIDX_LONG);
                            ptrSecond_nxt = 1'b0;
                            state_nxt = ST_PTR;
                        end
                    endcase
                end
            end
            ST_PTR: begin
                if (memValid) begin
                    if (ptrLong_r && !ptrSecond_r) begin
                        ptrSecond_nxt = 1'b1;
                        asmHigh = 1'b1;
                    end else begin
                        unique case (mode_r)
                            MODE_IND_SHORT, MODE_BIT_INDIRECT: begin
                                ea_nxt = {ZERO_BYTE, memData}; state_nxt = ST_DONE;
                            end
                            MODE_IND_LONG: begin
                                ea_nxt = {asmWord[15:8], memData}; state_nxt = ST_DONE;
                            end
                            MODE_INDIDX_SHORT: begin
                                ea_nxt = {ZERO_BYTE, memData} + {ZERO_BYTE, idx_r};
                                state_nxt = ST_DONE;
                            end
                            MODE_INDIDX_LONG: begin
                                ea_nxt = {asmWord[15:8], memData} + {ZERO_BYTE, idx_r};
                                state_nxt = ST_DONE;
                            end
                            MODE_REL_INDIRECT: begin
                                tgt_nxt = pcNext + {{8{memData[7]}}, memData};
                                state_nxt = ST_DONE;
                            end
                            MODE_BIT_IND_REL: begin
                                ea_nxt = {ZERO_BYTE, memData}; state_nxt = ST_OFFSET;
                            end
                            default: state_nxt = ST_DONE;
                        endcase
                    end
                end
            end
            ST_OFFSET: begin
                if (memValid) begin                                   // branch offset
                    tgt_nxt = pcNext + {{8{memData[7]}}, memData};
                    fetch_nxt = fetch_r + ONE_ADDR;
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                done_nxt  = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // pointer reads start in page zero (a long pointer at FF reads its low byte from 0100); offset fetch follows the pointer byte in code
    always_comb begin
        if (state_r == ST_PTR) memAddrC = ptrSecond_r ? ea_r + ONE_ADDR : ea_r;
        else memAddrC = fetch_r;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE; mode_r <= MODE_INHERENT; fetch_r <= ZERO_ADDR;
            ea_r <= ZERO_ADDR; tgt_r <= ZERO_ADDR; imm_r <= ZERO_BYTE;
            idx_r <= ZERO_BYTE; len_r <= 2'd0; cnt_r <= 2'd0; bit_r <= ZERO_BITNUM;
            useY_r <= 1'b0; done_r <= 1'b0; ptrLong_r <= 1'b0; ptrSecond_r <= 1'b0;
        end else if (clkEn) begin
            state_r <= state_nxt; mode_r <= mode_nxt; fetch_r <= fetch_nxt;
            ea_r <= ea_nxt; tgt_r <= tgt_nxt; imm_r <= imm_nxt;
            idx_r <= idx_nxt; len_r <= len_nxt; cnt_r <= cnt_nxt; bit_r <= bit_nxt;
            useY_r <= useY_nxt; done_r <= done_nxt; ptrLong_r <= ptrLong_nxt;
            ptrSecond_r <= ptrSecond_nxt;
        end
    end

    assign memReq         = (state_r == ST_OPERAND) || (state_r == ST_PTR) || (state_r == ST_OFFSET);
    assign memAddr        = memAddrC;
    assign busy           = (state_r != ST_IDLE);
    assign done           = done_r;
    assign effAddr        = ea_r;
    assign immValue       = imm_r;
    assign branchTarget   = tgt_r;
    assign bitNum         = bit_r;
    assign operandLen     = len_r;
    assign useSecondIndex = useY_r;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // first half of a long pointer read; the low half must follow at the next location
    sequence ptr_high_s;
        clkEn && state_r == ST_PTR && memValid && ptrLong_r && !ptrSecond_r;
    endsequence

    ptr_order_a: assert property (ptr_high_s |=> state_r == ST_PTR && memAddr == effAddr + ONE_ADDR)
        else $error("pointer low byte address wrong");
    inherent_nofetch_a: assert property (start && !busy && clkEn && modeSel == MODE_INHERENT
        |=> done && !memReq && operandLen == 2'd0) else $error("inherent fetched bytes");
    imm_len_a: assert property (start && !busy && clkEn && modeSel == MODE_IMMEDIATE
        |=> operandLen == 2'd1) else $error("immediate length wrong");
    short_page_a: assert property (done && (mode_r == MODE_DIR_SHORT || mode_r == MODE_IND_SHORT)
        |-> effAddr <= ZERO_PAGE_TOP) else $error("short address left page zero");
    long_len_a: assert property (start && !busy && clkEn && modeSel == MODE_DIR_LONG
        |=> operandLen == 2'd2) else $error("long direct length wrong");
    noidx_addr_a: assert property (start && !busy && clkEn && modeSel == MODE_IDX_NONE
        && prebyte != PREBYTE_Y |=> done && effAddr == {ZERO_BYTE, indexX} && operandLen == 2'd0)
        else $error("no offset index wrong");
    second_len_a: assert property (start && !busy && clkEn && modeSel == MODE_IDX_NONE
        && prebyte == PREBYTE_Y |=> operandLen == 2'd1 && useSecondIndex) else $error("second index length");
    short_idx_a: assert property (clkEn && state_r == ST_OPERAND && memValid && mode_r == MODE_IDX_SHORT
        |=> effAddr == {ZERO_BYTE, $past(memData)} + {ZERO_BYTE, idx_r}) else $error("short index sum");
    rmw_short_a: assert property (start && !busy && clkEn && rmwOp
        |=> mode_r != MODE_DIR_LONG && mode_r != MODE_IDX_LONG) else $error("rmw used long form");
    rel_target_a: assert property (clkEn && state_r == ST_OPERAND && memValid && mode_r == MODE_REL_DIRECT
        |=> branchTarget == $past(pcNext) + {{8{$past(memData[7])}}, $past(memData)})
        else $error("relative target wrong");
endmodule : cpu_operand_address_generator

// File: core/opaddr_pkg.sv
// shared constants and enumerations for the operand address generator
package opaddr_pkg;
    // -------------------------------------------------------------------
    // widths and fixed values
    // -------------------------------------------------------------------
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  PREBYTE_Y     = 8'h90;
    localparam logic [15:0] ZERO_PAGE_TOP = 16'h00FF;
    localparam logic [15:0] ZERO_ADDR     = 16'h0000;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    localparam logic [15:0] ONE_ADDR      = 16'h0001;
    localparam logic [2:0]  ZERO_BITNUM   = 3'h0;

    // -------------------------------------------------------------------
    // addressing modes presented by the opcode decoder
    // -------------------------------------------------------------------
    typedef enum logic [4:0] {
        MODE_INHERENT      = 5'h00,
        MODE_IMMEDIATE     = 5'h01,
        MODE_DIR_SHORT     = 5'h02,
        MODE_DIR_LONG      = 5'h03,
        MODE_IDX_NONE      = 5'h04,
        MODE_IDX_SHORT     = 5'h05,
        MODE_IDX_LONG      = 5'h06,
        MODE_IND_SHORT     = 5'h07,
        MODE_IND_LONG      = 5'h08,
        MODE_INDIDX_SHORT  = 5'h09,
        MODE_INDIDX_LONG   = 5'h0A,
        MODE_REL_DIRECT    = 5'h0B,
        MODE_REL_INDIRECT  = 5'h0C,
        MODE_BIT_DIRECT    = 5'h0D,
        MODE_BIT_INDIRECT  = 5'h0E,
        MODE_BIT_DIR_REL   = 5'h0F,
        MODE_BIT_IND_REL   = 5'h10
    } addr_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_OPERAND  = 3'h1,
        ST_PTR      = 3'h2,
        ST_OFFSET   = 3'h3,
        ST_DONE     = 3'h4
    } gen_state_e;
endpackage : opaddr_pkg

// File: core/byte_word_asm.sv
// assembles a big-endian word from two successive bytes
`timescale 1ns/100ps
module byte_word_asm
    import opaddr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic              clear,
    input  wire logic              loadHigh,
    input  wire logic              loadLow,
    input  wire logic [DATA_W-1:0] dataIn,
    output logic      [ADDR_W-1:0] word
);
    logic [ADDR_W-1:0] word_r;
    logic [ADDR_W-1:0] word_nxt;

    always_comb begin
        word_nxt = word_r;
        if (clear) begin
            word_nxt = ZERO_ADDR;
        end else if (loadHigh) begin
            word_nxt = {dataIn, ZERO_BYTE};
        end else if (loadLow) begin
            word_nxt = {word_r[ADDR_W-1:DATA_W], dataIn};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            word_r <= ZERO_ADDR;
        end else if (clkEn) begin
            word_r <= word_nxt;
        end
    end

    assign word = word_r;
endmodule : byte_word_asm

// File: testbench/operand_mem_model.sv
// program and data memory seen by the operand address generator
`timescale 1ns/100ps
module operand_mem_model
    import opaddr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic              slow,
    input  wire logic              memReq,
    input  wire logic [ADDR_W-1:0] memAddr,
    output logic                   memValid,
    output logic      [DATA_W-1:0] memData,
    output logic      [7:0]        beats
);
    logic [1:0]        waitCnt;
    logic [DATA_W-1:0] lastData;

    function automatic logic [DATA_W-1:0] cellValue(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : cellValue

    // slow mode answers on the third requested cycle
    assign memValid = memReq && (!slow || waitCnt == 2'h2);
    // no stale byte on the bus between answers
    assign memData  = memValid ? cellValue(memAddr) : ~lastData;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            waitCnt  <= 2'h0;
            lastData <= 8'h00;
            beats    <= 8'h00;
        end else if (clkEn && memValid) begin
            waitCnt  <= 2'h0;
            lastData <= memData;
            beats    <= beats + 8'h01;
        end else if (clkEn && memReq) begin
            waitCnt  <= waitCnt + 2'h1;
        end
    end
endmodule : operand_mem_model

// File: testbench/cpu_operand_address_generator_tb_top.sv
// self-checking bench for the operand address generator
`timescale 1ns/100ps
module cpu_operand_address_generator_tb_top;
    import opaddr_pkg::*;
    typedef struct {
        addr_mode_e  mode;
        logic [7:0]  pre;
        logic        rmw;
        logic [1:0]  len;
        logic [7:0]  reads;
        int          chk;
        logic [15:0] val;
        logic [15:0] tgt;
    } row_s;
    localparam logic [15:0] PC  = 16'h1230;
    localparam logic [7:0]  XV  = 8'hF0;
    localparam logic [7:0]  YV  = 8'hC7;
    logic        clk_sys, rst, clkEn, start, rmwOp, slow;
    logic [4:0]  modeIn;
    logic [7:0]  prebyte, opcode, indexX, indexY, memData, immValue, beats;
    logic [15:0] pcNext, memAddr, effAddr, branchTarget;
    logic        memReq, memValid, busy, done, useSecondIndex;
    logic [2:0]  bitNum;
    logic [1:0]  operandLen;
    logic [7:0]  b0, b1, pv;
    logic [15:0] pw;
    int          err_total, checks_done;
    row_s        rows[19];

    cpu_operand_address_generator dut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .start(start),
        .modeIn(modeIn), .prebyte(prebyte), .opcode(opcode), .rmwOp(rmwOp), .indexX(indexX),
        .indexY(indexY), .pcNext(pcNext), .memReq(memReq), .memAddr(memAddr), .memValid(memValid),
        .memData(memData), .busy(busy), .done(done), .effAddr(effAddr), .immValue(immValue),
        .branchTarget(branchTarget), .bitNum(bitNum), .operandLen(operandLen),
        .useSecondIndex(useSecondIndex));
    operand_mem_model mem (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .slow(slow), .memReq(memReq),
        .memAddr(memAddr), .memValid(memValid), .memData(memData), .beats(beats));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] memf(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : memf

    function automatic logic [15:0] sx(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction : sx

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset();
        rst = 1'b1;
        repeat (20) @(negedge clk_sys);
        check({busy, done, memReq, useSecondIndex}, 16'h0000);
        check(effAddr, 16'h0000);
        rst = 1'b0;
    endtask : do_reset

    // start is raised in the done cycle of the previous operation
    task automatic run_op(input row_s r);
        logic [7:0] b;
        int         n;
        modeIn  = r.mode;
        prebyte = r.pre;
        rmwOp   = r.rmw;
        start   = 1'b1;
        b       = beats;
        n       = 0;
        do begin
            @(negedge clk_sys);
            start = 1'b0;
            n++;
        end while (done !== 1'b1 && n < 60);
        if (done !== 1'b1) begin
            err_total++;
            give_verdict();
        end
        check(operandLen, r.len);
        check(beats - b, r.reads);
        if (r.chk[0]) check(effAddr, r.val);
        if (r.chk[1]) check(immValue, r.val);
        if (r.chk[2]) check(branchTarget, r.tgt);
        check(useSecondIndex, r.pre == PREBYTE_Y);
        if (r.mode >= MODE_BIT_DIRECT) check(bitNum, 3'h5);
    endtask : run_op

    initial begin
        {rst, clkEn, start, rmwOp, slow, modeIn, prebyte} = '0;
        clkEn  = 1'b1;
        opcode = 8'h1A;
        indexX = XV;
        indexY = YV;
        pcNext = PC;
        err_total   = 0;
        checks_done = 0;
        b0 = memf(PC);
        b1 = memf(PC + 16'h0001);
        pv = memf({8'h00, b0});
        pw = {pv, memf({8'h00, b0} + 16'h0001)};
        rows[0]  = '{MODE_INHERENT, 8'h00, 1'b0, 2'h0, 8'h00, 0, 16'h0000, 16'h0000};
        rows[1]  = '{MODE_IMMEDIATE, 8'h00, 1'b0, 2'h1, 8'h01, 2, {8'h00, b0}, 16'h0000};
        rows[2]  = '{MODE_DIR_SHORT, 8'h00, 1'b0, 2'h1, 8'h01, 1, {8'h00, b0}, 16'h0000};
        rows[3]  = '{MODE_DIR_LONG, 8'h00, 1'b0, 2'h2, 8'h02, 1, {b0, b1}, 16'h0000};
        rows[4]  = '{MODE_IDX_NONE, 8'h00, 1'b0, 2'h0, 8'h00, 1, {8'h00, XV}, 16'h0000};
        rows[5]  = '{MODE_IDX_NONE, PREBYTE_Y, 1'b0, 2'h1, 8'h00, 1, {8'h00, YV}, 16'h0000};
        rows[6]  = '{MODE_IDX_SHORT, 8'h00, 1'b0, 2'h1, 8'h01, 1, {8'h00, b0} + XV, 16'h0000};
        rows[7]  = '{MODE_IDX_SHORT, PREBYTE_Y, 1'b0, 2'h1, 8'h01, 1, {8'h00, b0} + YV, 16'h0000};
        rows[8]  = '{MODE_IDX_LONG, 8'h00, 1'b0, 2'h2, 8'h02, 1, {b0, b1} + XV, 16'h0000};
        rows[9]  = '{MODE_IND_SHORT, 8'h00, 1'b0, 2'h1, 8'h02, 1, {8'h00, pv}, 16'h0000};
        rows[10] = '{MODE_IND_LONG, 8'h00, 1'b0, 2'h1, 8'h03, 1, pw, 16'h0000};
        rows[11] = '{MODE_INDIDX_SHORT, 8'h00, 1'b0, 2'h1, 8'h02, 1, {8'h00, pv} + XV, 16'h0000};
        rows[12] = '{MODE_INDIDX_LONG, 8'h00, 1'b0, 2'h1, 8'h03, 1, pw + XV, 16'h0000};
        rows[13] = '{MODE_REL_DIRECT, 8'h00, 1'b0, 2'h1, 8'h01, 4, 16'h0000, PC + sx(b0)};
        rows[14] = '{MODE_REL_INDIRECT, 8'h00, 1'b0, 2'h1, 8'h02, 4, 16'h0000, PC + sx(pv)};
        rows[15] = '{MODE_BIT_DIRECT, 8'h00, 1'b0, 2'h1, 8'h01, 1, {8'h00, b0}, 16'h0000};
        rows[16] = '{MODE_BIT_INDIRECT, 8'h00, 1'b0, 2'h1, 8'h02, 1, {8'h00, pv}, 16'h0000};
        rows[17] = '{MODE_BIT_DIR_REL, 8'h00, 1'b0, 2'h2, 8'h02, 5, {8'h00, b0}, PC + sx(b1)};
        rows[18] = '{MODE_BIT_IND_REL, 8'h00, 1'b0, 2'h2, 8'h03, 5, {8'h00, pv}, PC + sx(b1)};
        do_reset();
        foreach (rows[i]) run_op(rows[i]);
        // a read-modify-write long form folds to its short form
        run_op('{MODE_DIR_LONG, 8'h00, 1'b1, 2'h1, 8'h01, 1, {8'h00, b0}, 16'h0000});
        run_op('{MODE_IDX_LONG, 8'h00, 1'b1, 2'h1, 8'h01, 1, {8'h00, b0} + XV, 16'h0000});
        // slow memory and a clock-enable pause in mid-transfer
        slow = 1'b1;
        fork
            run_op(rows[10]);
            begin
                repeat (3) @(negedge clk_sys);
                clkEn = 1'b0;
                repeat (4) @(negedge clk_sys);
                clkEn = 1'b1;
            end
        join
        slow = 1'b0;
        // reset in the middle of a pointer read, then a clean bit indirect relative operation
        modeIn = MODE_IND_LONG;
        start  = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        @(negedge clk_sys);
        do_reset();
        run_op(rows[18]);
        give_verdict();
    end
endmodule : cpu_operand_address_generator_tb_top
